// File: src/fss_sequencer.sv
// fault simulation sequencer: phase stepping, simulated quantities, trip gating
// assumes synchronous inputs on mclk; start, stop and external signals are levels or pulses as named
`timescale 1ns/1ps
module fss_sequencer #(
  parameter int TICK_CYC   = fss_pkg::TICK_CYC_DEF,
  parameter int RESET_MS   = fss_pkg::RESET_PHASE_MS,
  parameter int LOCKOUT_MS = fss_pkg::LOCKOUT_MS_DEF
) (
  input  wire logic                                        mclk,
  input  wire logic                                        rst,
  input  wire logic                                        ce,
  input  wire logic                                        start_cmd,
  input  wire logic                                        stop_cmd,
  input  wire logic                                        ext_sim_start,
  input  wire logic                                        ext_block_a,
  input  wire logic                                        ext_block_b,
  input  wire logic                                        ext_jump_to_post_fault,
  input  wire logic                                        ext_jump_assigned,
  input  wire logic                                        sim_trip_gating_mode,
  input  wire logic                                        protection_trip_command,
  input  wire logic [fss_pkg::DUR_W-1:0]                   cfg_pre_ms,
  input  wire logic [fss_pkg::DUR_W-1:0]                   cfg_fault_ms,
  input  wire logic [fss_pkg::DUR_W-1:0]                   cfg_post_ms,
  input  wire logic [fss_pkg::NCH-1:0][fss_pkg::VAL_W-1:0] cfg_volt_pre,
  input  wire logic [fss_pkg::NCH-1:0][fss_pkg::VAL_W-1:0] cfg_volt_fault,
  input  wire logic [fss_pkg::NCH-1:0][fss_pkg::VAL_W-1:0] cfg_volt_post,
  input  wire logic [fss_pkg::NCH-1:0][fss_pkg::VAL_W-1:0] cfg_curr_pre,
  input  wire logic [fss_pkg::NCH-1:0][fss_pkg::VAL_W-1:0] cfg_curr_fault,
  input  wire logic [fss_pkg::NCH-1:0][fss_pkg::VAL_W-1:0] cfg_curr_post,
  input  wire logic [fss_pkg::NCH-1:0][fss_pkg::VAL_W-1:0] cfg_angle_pre,
  input  wire logic [fss_pkg::NCH-1:0][fss_pkg::VAL_W-1:0] cfg_angle_fault,
  input  wire logic [fss_pkg::NCH-1:0][fss_pkg::VAL_W-1:0] cfg_angle_post,
  input  wire logic [fss_pkg::NPH-1:0][fss_pkg::VAL_W-1:0] meas_curr,
  input  wire logic [fss_pkg::VAL_W-1:0]                   nominal_curr,
  input  wire logic [fss_pkg::FREQ_W-1:0]                  rated_freq_mhz,
  output logic [2:0]                                       phase_code,
  output logic                                             sim_active,
  output logic                                             prot_reinit,
  output logic                                             energy_hold,
  output logic                                             trip_out,
  output logic                                             sim_volt_ph_n,
  output logic [fss_pkg::FREQ_W-1:0]                       sim_freq_mhz,
  output logic [fss_pkg::NCH-1:0][fss_pkg::VAL_W-1:0]      sim_volt,
  output logic [fss_pkg::NCH-1:0][fss_pkg::VAL_W-1:0]      sim_curr,
  output logic [fss_pkg::NCH-1:0][fss_pkg::VAL_W-1:0]      sim_angle,
  output logic                                             cur_over,
  output logic                                             restart_lockout
);

  localparam logic [fss_pkg::TICK_W-1:0] TICK_LAST = fss_pkg::TICK_W'(TICK_CYC - 1);
  localparam logic [fss_pkg::DUR_W-1:0]  RESET_DUR = fss_pkg::DUR_W'(RESET_MS);

  fss_pkg::fss_state_type state_ff;
  fss_pkg::fss_state_type nxt_state;

  logic [fss_pkg::TICK_W-1:0] tick_cnt_ff;
  logic [fss_pkg::DUR_W-1:0]  elapsed_ff;
  logic                       ext_start_prev_ff;
  logic                       jump_prev_ff;
  logic [2:0]                 phase_code_ff;
  logic [2:0]                 nxt_phase_code;
  logic                       sim_active_ff;
  logic                       prot_reinit_ff;
  logic                       energy_hold_ff;
  logic                       trip_out_ff;
  logic                       sim_volt_ph_n_ff;
  logic [fss_pkg::FREQ_W-1:0] sim_freq_ff;
  logic [fss_pkg::NCH-1:0][fss_pkg::VAL_W-1:0] sim_volt_ff;
  logic [fss_pkg::NCH-1:0][fss_pkg::VAL_W-1:0] sim_curr_ff;
  logic [fss_pkg::NCH-1:0][fss_pkg::VAL_W-1:0] sim_angle_ff;

  logic                       ms_tick;
  logic                       state_change;
  logic                       running;
  logic                       block_any;
  logic                       abort_req;
  logic                       abort_evt;
  logic                       cur_abort;
  logic                       ext_start_rise;
  logic                       jump_rise;
  logic                       jump_hit;
  logic                       start_ok;
  logic                       phase_done;
  logic                       in_reset;
  logic                       sel_pre;
  logic                       sel_fault;
  logic                       sel_post;
  logic                       nxt_trip;
  logic [fss_pkg::DUR_W-1:0]  cur_dur;
  logic [fss_pkg::FREQ_W+4:0] freq_prod;
  logic [fss_pkg::FREQ_W-1:0] freq_add;

  // current watch and lockout live in their own module
  fss_current_guard #(
    .LOCKOUT_MS (LOCKOUT_MS)
  ) u_guard (
    .mclk            (mclk),
    .rst             (rst),
    .ce              (ce),
    .ms_tick         (ms_tick),
    .abort_evt       (cur_abort),
    .meas_curr       (meas_curr),
    .nominal_curr    (nominal_curr),
    .cur_over        (cur_over),
    .restart_lockout (restart_lockout)
  );

  // request decode
  assign running        = state_ff != fss_pkg::st_idle;
  assign block_any      = ext_block_a | ext_block_b;
  assign abort_req      = block_any | cur_over;
  assign abort_evt      = ce && running && abort_req && !stop_cmd && state_ff != fss_pkg::st_rst_post;
  // only a current abort arms the restart lockout; a block abort must not hold off restarts
  assign cur_abort      = abort_evt & cur_over;
  assign ext_start_rise = ext_sim_start & ~ext_start_prev_ff;
  assign jump_rise      = ext_jump_to_post_fault & ~jump_prev_ff;
  // an unassigned jump input never cuts a phase short
  assign jump_hit       = ext_jump_assigned & jump_rise;
  assign start_ok       = (start_cmd | ext_start_rise) & ~block_any
                          & ~cur_over & ~restart_lockout;

  // duration of the phase in progress
  assign in_reset   = state_ff == fss_pkg::st_rst_pre || state_ff == fss_pkg::st_rst_post;
  assign sel_pre    = state_ff == fss_pkg::st_pre;
  assign sel_fault  = state_ff == fss_pkg::st_fault;
  assign sel_post   = state_ff == fss_pkg::st_post;
  assign cur_dur    = in_reset  ? RESET_DUR :
                      sel_pre   ? cfg_pre_ms :
                      sel_fault ? cfg_fault_ms : cfg_post_ms;
  assign phase_done = elapsed_ff >= cur_dur;
  assign ms_tick    = tick_cnt_ff == TICK_LAST;
  assign state_change = nxt_state != state_ff;

  // phase stepping; stop beats abort, abort beats normal stepping
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      fss_pkg::st_idle: begin
        if (start_ok)
          nxt_state = fss_pkg::st_rst_pre;
      end
      fss_pkg::st_rst_pre: begin
        if (phase_done)
          nxt_state = fss_pkg::st_pre;
      end
      fss_pkg::st_pre: begin
        if (jump_hit)
          nxt_state = fss_pkg::st_post;
        else if (phase_done)
          nxt_state = fss_pkg::st_fault;
      end
      fss_pkg::st_fault: begin
        if (jump_hit || phase_done)
          nxt_state = fss_pkg::st_post;
      end
      fss_pkg::st_post: begin
        if (phase_done)
          nxt_state = fss_pkg::st_rst_post;
      end
      fss_pkg::st_rst_post: begin
        if (phase_done)
          nxt_state = fss_pkg::st_idle;
      end
    endcase
    if (running && abort_req && state_ff != fss_pkg::st_rst_post)
      nxt_state = fss_pkg::st_rst_post;
    if (stop_cmd)
      nxt_state = fss_pkg::st_idle;
  end

  // phase code follows the next state so it lines up with state_ff
  always_comb begin
    unique case (nxt_state)
      fss_pkg::st_idle:     nxt_phase_code = fss_pkg::PH_NORMAL;
      fss_pkg::st_pre:      nxt_phase_code = fss_pkg::PH_PRE;
      fss_pkg::st_fault:    nxt_phase_code = fss_pkg::PH_FAULT;
      fss_pkg::st_post:     nxt_phase_code = fss_pkg::PH_POST;
      default:              nxt_phase_code = fss_pkg::PH_RESET;
    endcase
  end

  // trip path gated by mode only while simulating
  assign nxt_trip = protection_trip_command &
                    (~running | (sim_trip_gating_mode == fss_pkg::TRIP_MODE_WITH));

  // frequency raised by 0.16 %
  assign freq_prod = rated_freq_mhz * fss_pkg::FREQ_OFFS_NUM;
  assign freq_add  = fss_pkg::FREQ_W'(freq_prod / fss_pkg::FREQ_OFFS_DEN);

  // state, timing and edge history
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff          <= fss_pkg::st_idle;
      tick_cnt_ff       <= '0;
      elapsed_ff        <= '0;
      ext_start_prev_ff <= 1'b0;
      jump_prev_ff      <= 1'b0;
    end else if (ce) begin
      state_ff          <= nxt_state;
      ext_start_prev_ff <= ext_sim_start;
      jump_prev_ff      <= ext_jump_to_post_fault;
      // restart the ms grid at every phase change so durations are exact
      tick_cnt_ff       <= (state_change || ms_tick) ? '0 : tick_cnt_ff + 1'b1;
      if (state_change)
        elapsed_ff <= '0;
      else if (ms_tick && !phase_done)
        elapsed_ff <= elapsed_ff + 1'b1;
    end
  end

  // status and gating outputs
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase_code_ff    <= fss_pkg::PH_NORMAL;
      sim_active_ff    <= 1'b0;
      prot_reinit_ff   <= 1'b0;
      energy_hold_ff   <= 1'b0;
      trip_out_ff      <= 1'b0;
      sim_volt_ph_n_ff <= 1'b0;
      sim_freq_ff      <= '0;
    end else if (ce) begin
      phase_code_ff    <= nxt_phase_code;
      sim_active_ff    <= nxt_state != fss_pkg::st_idle;
      prot_reinit_ff   <= nxt_phase_code == fss_pkg::PH_RESET;
      energy_hold_ff   <= nxt_state != fss_pkg::st_idle;
      trip_out_ff      <= nxt_trip;
      sim_volt_ph_n_ff <= 1'b1;
      sim_freq_ff      <= rated_freq_mhz + freq_add;
    end
  end

  // simulated quantities per channel; zero outside the three main phases
  for (genvar c = 0; c < fss_pkg::NCH; c++) begin : g_chan
    logic [fss_pkg::VAL_W-1:0] nxt_volt;
    logic [fss_pkg::VAL_W-1:0] nxt_curr;
    logic [fss_pkg::VAL_W-1:0] nxt_angle;
    logic                      n_pre;
    logic                      n_fault;
    logic                      n_post;
    assign n_pre     = nxt_state == fss_pkg::st_pre;
    assign n_fault   = nxt_state == fss_pkg::st_fault;
    assign n_post    = nxt_state == fss_pkg::st_post;
    assign nxt_volt  = n_pre ? cfg_volt_pre[c] : n_fault ? cfg_volt_fault[c] :
                       n_post ? cfg_volt_post[c] : fss_pkg::VAL_ZERO;
    assign nxt_curr  = n_pre ? cfg_curr_pre[c] : n_fault ? cfg_curr_fault[c] :
                       n_post ? cfg_curr_post[c] : fss_pkg::VAL_ZERO;
    assign nxt_angle = n_pre ? cfg_angle_pre[c] : n_fault ? cfg_angle_fault[c] :
                       n_post ? cfg_angle_post[c] : fss_pkg::VAL_ZERO;
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        sim_volt_ff[c]  <= fss_pkg::VAL_ZERO;
        sim_curr_ff[c]  <= fss_pkg::VAL_ZERO;
        sim_angle_ff[c] <= fss_pkg::VAL_ZERO;
      end else if (ce) begin
        sim_volt_ff[c]  <= nxt_volt;
        sim_curr_ff[c]  <= nxt_curr;
        sim_angle_ff[c] <= nxt_angle;
      end
    end
  end

  assign phase_code    = phase_code_ff;
  assign sim_active    = sim_active_ff;
  assign prot_reinit   = prot_reinit_ff;
  assign energy_hold   = energy_hold_ff;
  assign trip_out      = trip_out_ff;
  assign sim_volt_ph_n = sim_volt_ph_n_ff;
  assign sim_freq_mhz  = sim_freq_ff;
  assign sim_volt      = sim_volt_ff;
  assign sim_curr      = sim_curr_ff;
  assign sim_angle     = sim_angle_ff;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence leave_pre_s;
    (state_ff == fss_pkg::st_pre && ce) ##1 (state_ff != fss_pkg::st_pre);
  endsequence

  chk_main_order: assert property (leave_pre_s |-> state_ff inside
    {fss_pkg::st_fault, fss_pkg::st_post, fss_pkg::st_rst_post, fss_pkg::st_idle})
    else $error("pre-fault left to an illegal phase");
  chk_reset_before_pre: assert property ($rose(state_ff == fss_pkg::st_pre) |->
    $past(state_ff) == fss_pkg::st_rst_pre)
    else $error("pre-fault entered without reset phase");
  chk_phase_code_map: assert property ((state_ff == fss_pkg::st_fault) |->
    (phase_code_ff == fss_pkg::PH_FAULT && !prot_reinit_ff))
    else $error("fault phase code wrong");
  chk_overcurrent_abort: assert property ((ce && cur_over && (sel_pre || sel_fault || sel_post))
    |=> state_ff inside {fss_pkg::st_rst_post, fss_pkg::st_idle})
    else $error("overcurrent did not abort");
  chk_lockout_start: assert property ((ce && !running && restart_lockout) |=> !running)
    else $error("start taken during lockout");
  chk_block_start: assert property ((ce && !running && block_any) |=> !running)
    else $error("start taken while blocked");
  chk_jump_post: assert property ((ce && jump_hit && (sel_pre || sel_fault) && !stop_cmd && !abort_req)
    |=> state_ff == fss_pkg::st_post ##0 phase_code_ff == fss_pkg::PH_POST)
    else $error("jump input did not reach post-fault");
  chk_energy_hold: assert property (energy_hold_ff == (phase_code_ff != fss_pkg::PH_NORMAL))
    else $error("energy hold out of step with simulation");
  chk_no_trip_mode: assert property ((ce && running && nxt_state != fss_pkg::st_idle
    && sim_trip_gating_mode == fss_pkg::TRIP_MODE_NONE) |=> !trip_out_ff)
    else $error("trip passed in no-trip mode");
  chk_with_trip_mode: assert property ((ce && running && protection_trip_command
    && sim_trip_gating_mode == fss_pkg::TRIP_MODE_WITH) |=> trip_out_ff)
    else $error("trip lost in with-trip mode");
  chk_stop_idle: assert property ((ce && stop_cmd) |=> (state_ff == fss_pkg::st_idle
    && phase_code_ff == fss_pkg::PH_NORMAL))
    else $error("stop did not return to normal");
  chk_start_ignored: assert property ((ce && sel_fault && start_ok && !stop_cmd)
    |=> state_ff != fss_pkg::st_rst_pre)
    else $error("start restarted a running simulation");
  chk_abort_reset: assert property ((ce && abort_evt) |=> (state_ff == fss_pkg::st_rst_post)
    [*2])
    else $error("abort skipped trailing reset phase");

endmodule

// File: src/fss_pkg.sv
// shared constants and types of the fault simulation sequencer
// assumes a single 25 MHz system clock; all phase timing is in milliseconds
package fss_pkg;

  // clock and time base
  localparam int CLK_PERIOD_PS = 40000;
  localparam int MS_PS         = 1000000000;
  localparam int TICK_CYC_DEF  = (MS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS; // cycles per ms, rounded up

  // timing figures
  localparam int RESET_PHASE_MS = 100;
  localparam int LOCKOUT_S      = 5;
  localparam int LOCKOUT_MS_DEF = LOCKOUT_S * 1000;

  // widths
  localparam int VAL_W  = 16;                // simulated and measured quantities
  localparam int DUR_W  = 16;                // configured phase durations in ms
  localparam int TICK_W = 16;                // prescaler width
  localparam int FREQ_W = 20;                // frequency in mHz
  localparam int NCH    = 4;                 // three phases plus ground
  localparam int NPH    = 3;                 // measured phase currents

  // phase codes reported to the recorders
  localparam logic [2:0] PH_NORMAL = 3'h0;
  localparam logic [2:0] PH_PRE    = 3'h1;
  localparam logic [2:0] PH_FAULT  = 3'h2;
  localparam logic [2:0] PH_POST   = 3'h3;
  localparam logic [2:0] PH_RESET  = 3'h4;

  // current limit 0.1 x nominal: meas * 10 > nominal
  localparam logic [3:0] CUR_LIMIT_DEN = 4'ha;

  // simulated frequency offset 0.16 % = 16 / 10000
  localparam logic [4:0]  FREQ_OFFS_NUM = 5'h10;
  localparam logic [13:0] FREQ_OFFS_DEN = 14'h2710;

  // trip gating modes
  localparam logic TRIP_MODE_NONE = 1'h0;
  localparam logic TRIP_MODE_WITH = 1'h1;

  // reset value of cleared quantities
  localparam logic [VAL_W-1:0] VAL_ZERO = 16'h0000;

  typedef enum logic [2:0] {
    st_idle,
    st_rst_pre,
    st_pre,
    st_fault,
    st_post,
    st_rst_post
  } fss_state_type;

endpackage

// File: src/fss_current_guard.sv
// phase current watch and restart lockout of the fault simulation sequencer
// assumes synchronous measured currents and a one-cycle ms tick from the sequencer
`timescale 1ns/1ps
module fss_current_guard #(
  parameter int LOCKOUT_MS = fss_pkg::LOCKOUT_MS_DEF
) (
  input  wire logic                                      mclk,
  input  wire logic                                      rst,
  input  wire logic                                      ce,
  input  wire logic                                      ms_tick,
  input  wire logic                                      abort_evt,
  input  wire logic [fss_pkg::NPH-1:0][fss_pkg::VAL_W-1:0] meas_curr,
  input  wire logic [fss_pkg::VAL_W-1:0]                 nominal_curr,
  output logic                                           cur_over,
  output logic                                           restart_lockout
);

  localparam logic [15:0] LOCKOUT_CNT = 16'(LOCKOUT_MS);

  logic [fss_pkg::NPH-1:0] over_ph;
  logic                    any_over;
  logic                    quiet_done;
  logic                    cur_over_ff;
  logic                    lockout_ff;
  logic [15:0]             quiet_ms_ff;
  logic [15:0]             nxt_quiet_ms;

  // per-phase compare against 0.1 x nominal, done as a multiply to avoid a divider
  for (genvar p = 0; p < fss_pkg::NPH; p++) begin : g_phase
    logic [fss_pkg::VAL_W+3:0] scaled;
    assign scaled     = meas_curr[p] * fss_pkg::CUR_LIMIT_DEN;
    assign over_ph[p] = scaled > {4'h0, nominal_curr};
  end

  assign any_over     = |over_ph;
  assign quiet_done   = quiet_ms_ff >= LOCKOUT_CNT;
  // quiet time restarts whenever current is back above the limit
  assign nxt_quiet_ms = any_over ? 16'h0000 :
                        (ms_tick && !quiet_done) ? quiet_ms_ff + 16'h0001 : quiet_ms_ff;

  // lockout set by an abort wins over its own clearing
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cur_over_ff <= 1'b0;
      lockout_ff  <= 1'b0;
      quiet_ms_ff <= 16'h0000;
    end else if (ce) begin
      cur_over_ff <= any_over;
      quiet_ms_ff <= abort_evt ? 16'h0000 : nxt_quiet_ms;
      if (abort_evt)
        lockout_ff <= 1'b1;
      else if (quiet_done && !any_over)
        lockout_ff <= 1'b0;
    end
  end

  assign cur_over        = cur_over_ff;
  assign restart_lockout = lockout_ff;

  // lockout cannot drop while current is still above the limit
  chk_lockout_held: assert property (@(posedge mclk) disable iff (rst)
    (lockout_ff && any_over && ce) |=> lockout_ff)
    else $error("restart lockout released while current above limit");

endmodule

// File: dv/fss_far_side.sv
// far-side model: protection functions, trip decision and phase current sensing
// assumes phase_code from the sequencer and levels chosen by the bench
`timescale 1ns/1ps
module fss_far_side (
  input  wire logic        mclk,
  input  wire logic [2:0]  phase_code,
  input  wire logic        trip_en,
  input  wire logic [15:0] curr_lvl,
  output logic             protection_trip_command,
  output logic [2:0][15:0] meas_curr
);
  // protection reaches a trip decision only while the fault is simulated
  always_ff @(posedge mclk) begin
    protection_trip_command <= trip_en && (phase_code == fss_pkg::PH_FAULT);
  end
  // one level on all three phases; enough to cross the limit on any of them
  assign meas_curr = {3{curr_lvl}};
endmodule

// File: dv/fault_simulation_sequencer_bench.sv
// bench of the fault simulation sequencer with short ms and lockout counts
// assumes the sequencer and the far-side model; prints mismatches and a verdict
`timescale 1ns/1ps
module fault_simulation_sequencer_bench;
  logic mclk, rst, ce, start_cmd, stop_cmd, ext_sim_start, ext_block_a, ext_block_b, trip_en;
  logic ext_jump_to_post_fault, ext_jump_assigned, sim_trip_gating_mode, protection_trip_command;
  logic energy_hold, trip_out, sim_volt_ph_n, restart_lockout, sim_active, prot_reinit, cur_over;
  logic [2:0] phase_code;
  logic [15:0] cfg_pre_ms, cfg_fault_ms, cfg_post_ms, nominal_curr, curr_lvl;
  logic [19:0] rated_freq_mhz, sim_freq_mhz;
  logic [2:0][15:0] meas_curr;
  logic [3:0][15:0] cfg_volt_pre, cfg_volt_fault, cfg_volt_post, cfg_curr_pre, cfg_curr_fault;
  logic [3:0][15:0] cfg_curr_post, cfg_angle_pre, cfg_angle_fault, cfg_angle_post, sim_curr, sim_volt, sim_angle;
  int err_count, checks_done, cyc, n;
  fss_sequencer #(.TICK_CYC(4), .RESET_MS(2), .LOCKOUT_MS(3)) fss_sequencer_i (
    .mclk, .rst, .ce, .start_cmd, .stop_cmd, .ext_sim_start, .ext_block_a, .ext_block_b,
    .ext_jump_to_post_fault, .ext_jump_assigned, .sim_trip_gating_mode, .protection_trip_command,
    .cfg_pre_ms, .cfg_fault_ms, .cfg_post_ms, .cfg_volt_pre, .cfg_volt_fault, .cfg_volt_post,
    .cfg_curr_pre, .cfg_curr_fault, .cfg_curr_post, .cfg_angle_pre, .cfg_angle_fault, .cfg_angle_post,
    .meas_curr, .nominal_curr, .rated_freq_mhz, .phase_code, .sim_active, .prot_reinit, .energy_hold,
    .trip_out, .sim_volt_ph_n, .sim_freq_mhz, .sim_volt, .sim_curr, .sim_angle, .cur_over,
    .restart_lockout);
  fss_far_side fss_far_side_i (.mclk, .phase_code, .trip_en, .curr_lvl, .protection_trip_command, .meas_curr);
  // clock, and a cycle ceiling well above the fewer than 200 cycles the scenarios need
  initial begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (err_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    step(1);
    s = 0;
  endtask
  // waits for the phase code to move; n holds how many cycles passed between the call and the move
  task automatic next_code(input logic [2:0] exp);
    logic [2:0] prev;
    prev = phase_code;
    n = 0;
    while (phase_code === prev && n < 400) begin
      step(1);
      n++;
    end
    cmp(phase_code, exp);
  endtask
  // cold run: full cycle, timings, values, frequency offset, trip blocked
  task automatic s_full();
    pulse(start_cmd);
    cmp(phase_code, fss_pkg::PH_RESET);
    cmp(energy_hold, 1'b1);
    cmp(prot_reinit, 1'b1);
    next_code(fss_pkg::PH_PRE);
    cmp(n, 9);
    cmp(prot_reinit, 1'b0);
    cmp(sim_volt, cfg_volt_pre);
    next_code(fss_pkg::PH_FAULT);
    cmp(n, 9);
    // unassigned jump input must not cut the fault phase short; four cycles used here
    pulse(ext_jump_to_post_fault);
    step(3);
    cmp(sim_curr, cfg_curr_fault);
    cmp(sim_angle, cfg_angle_fault);
    cmp(trip_out, 1'b0);
    next_code(fss_pkg::PH_POST);
    cmp(n + 4, 13);
    next_code(fss_pkg::PH_RESET);
    next_code(fss_pkg::PH_NORMAL);
    cmp(energy_hold, 1'b0);
    cmp(sim_active, 1'b0);
    cmp(sim_freq_mhz, 20'h0_c3a0);
    cmp(sim_volt_ph_n, 1'b1);
  endtask
  // hot run with starts ignored in pre-fault and fault, then a manual stop
  task automatic s_hot();
    sim_trip_gating_mode = 1;
    pulse(start_cmd);
    next_code(fss_pkg::PH_PRE);
    pulse(start_cmd);
    next_code(fss_pkg::PH_FAULT);
    pulse(start_cmd);
    cmp(phase_code, fss_pkg::PH_FAULT);
    step(3);
    cmp(trip_out, 1'b1);
    pulse(stop_cmd);
    cmp(phase_code, fss_pkg::PH_NORMAL);
  endtask
  // external start, then jump straight from pre-fault to post-fault
  task automatic s_jump();
    ext_jump_assigned = 1;
    ext_sim_start = 1;
    step(1);
    cmp(phase_code, fss_pkg::PH_RESET);
    ext_sim_start = 0;
    next_code(fss_pkg::PH_PRE);
    pulse(ext_jump_to_post_fault);
    cmp(phase_code, fss_pkg::PH_POST);
    pulse(stop_cmd);
  endtask
  // block refuses a start and aborts a run through the trailing reset
  task automatic s_block();
    ext_block_a = 1;
    pulse(start_cmd);
    step(2);
    cmp(phase_code, fss_pkg::PH_NORMAL);
    ext_block_a = 0;
    pulse(start_cmd);
    next_code(fss_pkg::PH_PRE);
    ext_block_b = 1;
    next_code(fss_pkg::PH_RESET);
    next_code(fss_pkg::PH_NORMAL);
    ext_block_b = 0;
  endtask
  // live current aborts, then lockout refuses restart until the quiet time ran out
  task automatic s_curr();
    pulse(start_cmd);
    next_code(fss_pkg::PH_PRE);
    curr_lvl = 16'h000b;
    next_code(fss_pkg::PH_RESET);
    cmp(cur_over, 1'b1);
    cmp(restart_lockout, 1'b1);
    // current stays high a little into the lockout so its hold is exercised
    step(2);
    curr_lvl = 16'h000a;
    next_code(fss_pkg::PH_NORMAL);
    pulse(start_cmd);
    step(2);
    cmp(phase_code, fss_pkg::PH_NORMAL);
    step(30);
    cmp(restart_lockout, 1'b0);
    pulse(start_cmd);
    cmp(phase_code, fss_pkg::PH_RESET);
    // clock enable low freezes the reset phase well past its length
    ce = 0;
    step(20);
    cmp(phase_code, fss_pkg::PH_RESET);
    ce = 1;
    pulse(stop_cmd);
  endtask
  initial begin
    {rst, ce, start_cmd, stop_cmd, ext_sim_start, ext_block_a, ext_block_b} = 7'h60;
    {ext_jump_to_post_fault, ext_jump_assigned, sim_trip_gating_mode, trip_en} = 4'h1;
    {cfg_pre_ms, cfg_fault_ms, cfg_post_ms, nominal_curr, curr_lvl} = {16'h0002, 16'h0003, 16'h0002, 16'h0064, 16'h0001};
    rated_freq_mhz = 20'h0_c350;
    {cfg_volt_pre, cfg_volt_fault, cfg_volt_post, cfg_curr_pre} = {16{16'h0003}};
    {cfg_curr_post, cfg_angle_pre, cfg_angle_fault, cfg_angle_post} = {16{16'h0005}};
    cfg_curr_fault = {16'h0007, 16'h0008, 16'h0009, 16'h000a};
    step(3);
    rst = 0;
    step(1);
    s_full();
    s_hot();
    s_jump();
    s_block();
    s_curr();
    stop_test();
  end
endmodule
